// [include/sao_pkg.sv]
`default_nettype none
package sao_pkg;

	localparam int REG_W = 16;

	// Alarm event field positions
	localparam int ALM_QUEUE = 4;
	localparam int ALM_ALARM_LO = 6;
	localparam int ALM_LOWER = 12;
	localparam int ALM_UPPER = 13;
	localparam logic [15:0] ALM_MASK = 16'h33D0;
	localparam logic [15:0] ALM_RESET = 16'h0000;

	// Operation field positions
	localparam int OP_CAL = 0;
	localparam int OP_SELF = 1;
	localparam int OP_SCAN = 4;
	localparam int OP_WAIT_TRIG = 5;
	localparam int OP_EXT_STORE = 7;
	localparam int OP_CFG_CHG = 8;
	localparam int OP_MEM_THR = 9;
	localparam int OP_LOCKED = 10;
	localparam int OP_SET_CHG = 11;
	localparam int OP_ERR_Q = 13;
	localparam int OP_BUSY = 14;
	localparam logic [15:0] COND_MASK = 16'h65B3;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;

	typedef enum logic [2:0] {
		SAO_NOP = 3'h0,
		SAO_RD_ALARM = 3'h1,
		SAO_RD_COND = 3'h2,
		SAO_RD_ENABLE = 3'h3,
		SAO_WR_ENABLE = 3'h4,
		SAO_CLEAR_STATUS = 3'h5,
		SAO_PRESET = 3'h6,
		SAO_FACTORY_RESET = 3'h7
	} sao_cmd_t;

	typedef struct packed {
		sao_cmd_t code;
		logic [15:0] value;
	} sao_req_t;

	typedef struct packed {
		logic calibrating;
		logic self_test;
		logic scanning;
		logic awaiting_trigger_flag;
		logic external_storage_present;
		logic config_changed;
		logic locked;
		logic error_queue_nonempty;
		logic busy;
		logic mem_threshold;
		logic settings_changed;
	} sao_live_t;

	typedef struct packed {
		logic queue_nonempty;
		logic [3:0] alarm;
		logic lower_limit;
		logic upper_limit;
	} sao_alarm_t;

endpackage
`default_nettype wire

// [rtl/sao_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module sao_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sao_sync
`default_nettype wire

// [rtl/sao_status_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module sao_status_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Command port
	input wire logic req_valid,
	input wire sao_pkg::sao_req_t req,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	// Instrument state inputs
	input wire sao_pkg::sao_live_t live_in,
	input wire sao_pkg::sao_alarm_t alarm_in,
	// Toward status byte
	output logic summary
);
	sao_pkg::sao_live_t live_s;
	sao_pkg::sao_alarm_t alarm_s;
	logic [15:0] alarm_event_latch;
	logic [15:0] operation_condition;
	logic [15:0] operation_enable_mask;
	logic [15:0] alarm_set;
	logic [15:0] op_events;
	logic cfg_flag;
	logic rd_alarm, rd_cond, rd_enable, wr_enable, clear_status, preset, factory_reset;

	sao_sync #(.W($bits(sao_pkg::sao_live_t))) u_live_sync (
		.clk(clk),
		.rstn(rstn),
		.d(live_in),
		.q(live_s)
	);

	sao_sync #(.W($bits(sao_pkg::sao_alarm_t))) u_alarm_sync (
		.clk(clk),
		.rstn(rstn),
		.d(alarm_in),
		.q(alarm_s)
	);

	assign rd_alarm = req_valid && (req.code == sao_pkg::SAO_RD_ALARM);
	assign rd_cond = req_valid && (req.code == sao_pkg::SAO_RD_COND);
	assign rd_enable = req_valid && (req.code == sao_pkg::SAO_RD_ENABLE);
	assign wr_enable = req_valid && (req.code == sao_pkg::SAO_WR_ENABLE);
	assign clear_status = req_valid && (req.code == sao_pkg::SAO_CLEAR_STATUS);
	assign preset = req_valid && (req.code == sao_pkg::SAO_PRESET);
	assign factory_reset = req_valid && (req.code == sao_pkg::SAO_FACTORY_RESET);

	always_comb begin
		alarm_set = 16'h0000;
		alarm_set[sao_pkg::ALM_QUEUE] = alarm_s.queue_nonempty;
		alarm_set[sao_pkg::ALM_ALARM_LO +: 4] = alarm_s.alarm;
		alarm_set[sao_pkg::ALM_LOWER] = alarm_s.lower_limit;
		alarm_set[sao_pkg::ALM_UPPER] = alarm_s.upper_limit;
	end

	// sticky with read-clear
	// A source still active on the clearing cycle re-sets its bit, so no event is lost.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarm_event_latch <= sao_pkg::ALM_RESET;
		end else if (rd_alarm || clear_status) begin
			alarm_event_latch <= alarm_set & sao_pkg::ALM_MASK;
		end else begin
			alarm_event_latch <= (alarm_event_latch | alarm_set) & sao_pkg::ALM_MASK;
		end
	end

	// factory reset marks the configuration changed
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_flag <= 1'b0;
		end else if (factory_reset) begin
			cfg_flag <= 1'b1;
		end else if (clear_status) begin
			cfg_flag <= 1'b0;
		end
	end

	// condition layout, unused bits stay zero
	always_comb begin
		operation_condition = 16'h0000;
		operation_condition[sao_pkg::OP_CAL] = live_s.calibrating;
		operation_condition[sao_pkg::OP_SELF] = live_s.self_test;
		operation_condition[sao_pkg::OP_SCAN] = live_s.scanning;
		operation_condition[sao_pkg::OP_WAIT_TRIG] = live_s.awaiting_trigger_flag;
		operation_condition[sao_pkg::OP_EXT_STORE] = live_s.external_storage_present;
		operation_condition[sao_pkg::OP_CFG_CHG] = live_s.config_changed | cfg_flag;
		operation_condition[sao_pkg::OP_LOCKED] = live_s.locked;
		operation_condition[sao_pkg::OP_ERR_Q] = live_s.error_queue_nonempty;
		operation_condition[sao_pkg::OP_BUSY] = live_s.busy;
	end

	always_comb begin
		op_events = operation_condition;
		op_events[sao_pkg::OP_MEM_THR] = live_s.mem_threshold;
		op_events[sao_pkg::OP_SET_CHG] = live_s.settings_changed;
	end

	// full 16-bit write stored as given
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			operation_enable_mask <= sao_pkg::ENABLE_RESET;
		end else if (preset) begin
			operation_enable_mask <= sao_pkg::ENABLE_RESET;
		end else if (wr_enable) begin
			operation_enable_mask <= req.value;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			summary <= 1'b0;
		end else begin
			summary <= |(op_events & operation_enable_mask);
		end
	end

	// answer with the binary weighted value
	// condition read has no side effect
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
		end else begin
			rsp_valid <= rd_alarm || rd_cond || rd_enable;
			if (rd_alarm) begin
				rsp_data <= alarm_event_latch;
			end else if (rd_cond) begin
				rsp_data <= operation_condition;
			end else if (rd_enable) begin
				rsp_data <= operation_enable_mask;
			end
		end
	end

	chk_alarm_sticky: assert property (@(posedge clk) disable iff (!rstn)
		!(rd_alarm || clear_status) |=> ((alarm_event_latch & $past(alarm_event_latch))
		== $past(alarm_event_latch))) else $error("alarm bit lost without clear");

	// read clears when sources are quiet
	chk_alarm_read_clear: assert property (@(posedge clk) disable iff (!rstn)
		(rd_alarm && alarm_set == 16'h0000) |=> (alarm_event_latch == 16'h0000))
		else $error("alarm register not cleared by read");

	chk_alarm_reserved: assert property (@(posedge clk) disable iff (!rstn)
		((alarm_event_latch & ~sao_pkg::ALM_MASK) == 16'h0000))
		else $error("reserved alarm bit set");

	chk_alarm_read_value: assert property (@(posedge clk) disable iff (!rstn)
		rd_alarm |=> (rsp_valid && rsp_data == $past(alarm_event_latch)))
		else $error("alarm read returned wrong value");

	chk_cond_read_pure: assert property (@(posedge clk) disable iff (!rstn)
		rd_cond ##1 $stable(live_s) |-> $stable(operation_condition))
		else $error("condition read changed condition bits");

	chk_busy_bit: assert property (@(posedge clk) disable iff (!rstn)
		$rose(live_in.busy) |-> ##2 operation_condition[sao_pkg::OP_BUSY])
		else $error("busy bit not raised two cycles after input");

	chk_factory_cfg: assert property (@(posedge clk) disable iff (!rstn)
		factory_reset |=> operation_condition[sao_pkg::OP_CFG_CHG] [*1])
		else $error("factory reset did not set config changed");

	chk_cond_reserved: assert property (@(posedge clk) disable iff (!rstn)
		((operation_condition & ~sao_pkg::COND_MASK) == 16'h0000))
		else $error("unused condition bit set");

	// error queue bit tracks the pin two edges later
	chk_err_queue_bit: assert property (@(posedge clk) disable iff (!rstn)
		operation_condition[sao_pkg::OP_ERR_Q] == $past(live_in.error_queue_nonempty, 2))
		else $error("error queue bit mismatch");

	chk_preset_zero: assert property (@(posedge clk) disable iff (!rstn)
		preset |=> (operation_enable_mask == 16'h0000))
		else $error("preset left enable bits set");

	chk_enable_readback: assert property (@(posedge clk) disable iff (!rstn)
		wr_enable ##1 rd_enable |=> (rsp_valid && rsp_data == $past(req.value, 2)))
		else $error("enable readback differs from write");

	chk_summary_set: assert property (@(posedge clk) disable iff (!rstn)
		((|(operation_condition & operation_enable_mask))
		|| (live_s.mem_threshold && operation_enable_mask[sao_pkg::OP_MEM_THR])
		|| (live_s.settings_changed && operation_enable_mask[sao_pkg::OP_SET_CHG]))
		|=> summary)
		else $error("summary low with an enabled event");

	// no enabled event keeps summary low
	chk_summary_clr: assert property (@(posedge clk) disable iff (!rstn)
		!((|(operation_condition & operation_enable_mask))
		|| (live_s.mem_threshold && operation_enable_mask[sao_pkg::OP_MEM_THR])
		|| (live_s.settings_changed && operation_enable_mask[sao_pkg::OP_SET_CHG]))
		|=> !summary)
		else $error("summary high with no enabled event");

	// memory threshold gated by bit 9
	chk_mem_thr_gate: assert property (@(posedge clk) disable iff (!rstn)
		(live_s.mem_threshold && operation_enable_mask[sao_pkg::OP_MEM_THR]) |=> summary)
		else $error("memory threshold not forwarded");

	// settings changed gated by bit 11
	chk_set_chg_gate: assert property (@(posedge clk) disable iff (!rstn)
		(live_s.settings_changed && operation_enable_mask[sao_pkg::OP_SET_CHG]) |=> summary)
		else $error("settings changed not forwarded");
endmodule // sao_status_regs
`default_nettype wire

// [bench/sao_status_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module sao_status_regs_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	sao_pkg::sao_req_t req = '0;
	sao_pkg::sao_live_t live_in = '0;
	sao_pkg::sao_alarm_t alarm_in = '0;
	sao_pkg::sao_alarm_t acc;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic summary;
	logic [15:0] d;
	logic [15:0] en;
	logic cfg;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;

	sao_status_regs uut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .live_in(live_in),
		.alarm_in(alarm_in), .summary(summary));

	always #5 clk = ~clk;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	function automatic logic [15:0] cond_exp(sao_pkg::sao_live_t l, logic f);
		return {1'b0, l.busy, l.error_queue_nonempty, 2'b00, l.locked, 1'b0,
			l.config_changed | f, l.external_storage_present, 1'b0,
			l.awaiting_trigger_flag, l.scanning, 2'b00, l.self_test, l.calibrating};
	endfunction

	function automatic logic [15:0] ev_exp(sao_pkg::sao_live_t l, logic f);
		return cond_exp(l, f) | {4'h0, l.settings_changed, 1'b0, l.mem_threshold, 9'h000};
	endfunction

	function automatic logic [15:0] alm_exp(sao_pkg::sao_alarm_t a);
		return {2'b00, a.upper_limit, a.lower_limit, 2'b00, a.alarm, 1'b0, a.queue_nonempty, 4'h0};
	endfunction

	// Answer is sampled just after the edge that takes the command
	task automatic cmd(input sao_pkg::sao_cmd_t c, input logic [15:0] v);
		logic rd;
		rd = c inside {sao_pkg::SAO_RD_ALARM, sao_pkg::SAO_RD_COND, sao_pkg::SAO_RD_ENABLE};
		@(posedge clk) #1;
		req_valid = 1'b1;
		req.code = c;
		req.value = v;
		@(posedge clk) #1;
		req_valid = 1'b0;
		d = rsp_data;
		check("rsp_valid", {15'h0000, rsp_valid}, {15'h0000, rd});
	endtask

	// Write then read back on consecutive edges, strobe held high between them
	task automatic wr_rd(input logic [15:0] v);
		@(posedge clk) #1;
		req_valid = 1'b1;
		req.code = sao_pkg::SAO_WR_ENABLE;
		req.value = v;
		@(posedge clk) #1;
		req.code = sao_pkg::SAO_RD_ENABLE;
		@(posedge clk) #1;
		req_valid = 1'b0;
		d = rsp_data;
		check("rsp_valid b2b", {15'h0000, rsp_valid}, 16'h0001);
	endtask

	// Inputs pass two sync flops and a summary register
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	initial begin
		void'($urandom(32'hdcd3));
		cfg = 1'b0;
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		cmd(sao_pkg::SAO_RD_ENABLE, 16'h0000);
		check("enable reset", d, sao_pkg::ENABLE_RESET);
		cmd(sao_pkg::SAO_RD_ALARM, 16'h0000);
		check("alarm reset", d, sao_pkg::ALM_RESET);
		for (int i = 0; i < 8; i++) begin
			en = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
			if (i[0]) begin
				wr_rd(en);
			end else begin
				cmd(sao_pkg::SAO_WR_ENABLE, en);
				cmd(sao_pkg::SAO_RD_ENABLE, 16'h0000);
			end
			check("enable", d, en);
		end
		// Corner cases first: lone threshold, lone settings change, busy masked off
		for (int i = 0; i < 12; i++) begin
			case (i)
				0: begin live_in = '1; en = 16'hFFFF; end
				1: begin live_in = 11'h002; en = 16'h0200; end
				2: begin live_in = 11'h001; en = 16'h0800; end
				3: begin live_in = 11'h004; en = 16'hBFFF; end
				default: begin live_in = 11'($urandom); en = 16'($urandom); end
			endcase
			cmd(sao_pkg::SAO_WR_ENABLE, en);
			settle();
			check("summary", {15'h0000, summary}, {15'h0000, |(ev_exp(live_in, cfg) & en)});
			cmd(sao_pkg::SAO_RD_COND, 16'h0000);
			check("cond", d, cond_exp(live_in, cfg));
			cmd(sao_pkg::SAO_RD_COND, 16'h0000);
			check("cond reread", d, cond_exp(live_in, cfg));
		end
		// Odd passes clear by command instead of by read
		for (int i = 0; i < 6; i++) begin
			acc = (i == 0) ? '1 : 7'($urandom);
			alarm_in = acc;
			settle();
			alarm_in = '0;
			settle();
			cmd(i[0] ? sao_pkg::SAO_CLEAR_STATUS : sao_pkg::SAO_RD_ALARM, 16'h0000);
			if (!i[0]) check("alarm", d, alm_exp(acc));
			cmd(sao_pkg::SAO_RD_ALARM, 16'h0000);
			check("alarm cleared", d, 16'h0000);
		end
		live_in = '0;
		settle();
		cmd(sao_pkg::SAO_FACTORY_RESET, 16'h0000);
		cfg = 1'b1;
		cmd(sao_pkg::SAO_RD_COND, 16'h0000);
		check("cond factory", d, cond_exp(live_in, cfg));
		live_in = '1;
		cmd(sao_pkg::SAO_WR_ENABLE, 16'hFFFF);
		settle();
		check("summary on", {15'h0000, summary}, 16'h0001);
		cmd(sao_pkg::SAO_PRESET, 16'h0000);
		cmd(sao_pkg::SAO_RD_ENABLE, 16'h0000);
		check("enable preset", d, 16'h0000);
		check("summary off", {15'h0000, summary}, 16'h0000);
		report_and_stop();
	end
endmodule // sao_status_regs_tb
`default_nettype wire
